/* File: core/rpss_seq.sv */
// protection and startup sequencer for a resonant half-bridge controller
`timescale 1ns/1ps
`default_nettype none
`include "rpss_regs.svh"
module rpss_seq
    import rpss_pkg::*;
#(
    parameter int unsigned FAULT_IDLE_CYC = (`RPSS_CLK_HZ / 1000) * `RPSS_FAULT_IDLE_MS,
    parameter int unsigned SS_STEP_CYC    = ((`RPSS_CLK_HZ / 1000) * `RPSS_SS_TIME_MS) / 256,
    parameter int unsigned ZCS_FAULT_CYC  = 25000,
    parameter int unsigned OLP_CYC        = 1250000,
    parameter logic [7:0]  SS_MIN         = 8'h40
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        gate_req_hi,
    input  wire logic        gate_req_lo,
    input  wire logic        zcs_cmp,
    input  wire logic        ocp_cmp,
    input  wire logic        olp_cmp,
    input  wire logic        bias_ov,
    input  wire logic        bias_above_short,
    input  wire logic        bias_above_uvlo_r,
    input  wire logic        bias_above_uvlo_f,
    input  wire logic        bias_above_self,
    input  wire logic        bias_above_recharge,
    input  wire logic        bias_above_stop,
    input  wire logic        init_done,
    output logic             high_side_gate,
    output logic             low_side_gate,
    output logic             charge_low_en,
    output logic             charge_high_en,
    output logic             rail_5v_en,
    output logic             program_sample,
    output logic             timing_pin_high,
    output logic             power_limit,
    output logic [7:0]       soft_start_ramp,
    output logic [7:0]       turnoff_level
);
    localparam int unsigned BLANK_CYC = (`RPSS_BLANK_NS * (`RPSS_CLK_HZ / 1000000) + 999) / 1000;
    localparam int NIN = 13;

    // two-flop synchronisers for every pin input
    logic [NIN-1:0] s1_q, s2_q;
    logic [NIN-1:0] pins;
    assign pins = {gate_req_hi, gate_req_lo, zcs_cmp, ocp_cmp, olp_cmp, bias_ov, bias_above_short,
                   bias_above_uvlo_r, bias_above_uvlo_f, bias_above_self, bias_above_recharge,
                   bias_above_stop, init_done};
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= pins;
            s2_q <= s1_q;
        end
    end
    logic req_hi, req_lo, zcs, ocp, olp, ovp, a_short, a_uvr, a_uvf, a_self, a_rech, a_stop, i_done;
    assign {req_hi, req_lo, zcs, ocp, olp, ovp, a_short, a_uvr, a_uvf, a_self, a_rech, a_stop, i_done} = s2_q;

    // register bus: control, status, demand, comparator view
    logic [31:0] ctrl_q, ctrl_d, demand_q, demand_d;
    logic        wr_pend_q, wr_pend_d;
    logic [11:0] wr_addr_q, wr_addr_d;
    logic [31:0] rdata_q, rdata_d;
    logic        hv_en, retry_en;
    assign hv_en    = ctrl_q[`RPSS_CTRL_HV_BIT];
    assign retry_en = ctrl_q[`RPSS_CTRL_RETRY_BIT];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_q;

    // sequencer state
    rpss_state_t st_q, st_d;
    rpss_fault_t cause_q, cause_d;
    logic [31:0] idle_q, idle_d, zcs_t_q, zcs_t_d, olp_t_q, olp_t_d, ss_t_q, ss_t_d;
    logic [7:0]  ramp_q, ramp_d, ocp_n_q, ocp_n_d;
    logic [3:0]  blank_q, blank_d;
    logic        hi_q, hi_d, lo_q, lo_d, cyc_ocp_q, cyc_ocp_d, zcs_seen_q, zcs_seen_d;
    logic        hi_prev_q, hi_prev_d, lo_prev_q, lo_prev_d, prog_q, prog_d;
    logic        chg_q, chg_d;
    logic        zcs_ev, ocp_ev, cyc_end, switching;
    logic [7:0]  ocp_lim;

    always_comb begin
        ctrl_d    = ctrl_q;
        demand_d  = demand_q;
        wr_pend_d = hsel && hready && htrans[1] && hwrite;
        wr_addr_d = haddr;
        rdata_d   = rdata_q;
        if (wr_pend_q) begin
            unique case (wr_addr_q)
                `RPSS_CTRL_ADDR:   ctrl_d   = {30'h0, hwdata[1:0]};
                `RPSS_DEMAND_ADDR: demand_d = {24'h0, hwdata[7:0]};
                default: ;
            endcase
        end
        if (hsel && hready && htrans[1] && !hwrite) begin
            unique case (haddr)
                `RPSS_CTRL_ADDR:   rdata_d = ctrl_q;
                `RPSS_STATUS_ADDR: rdata_d = {13'h0, cause_q, ocp_n_q, 5'h0, st_q};
                `RPSS_DEMAND_ADDR: rdata_d = demand_q;
                `RPSS_CMPVAL_ADDR: rdata_d = {19'h0, s2_q};
                default:           rdata_d = 32'h0000_0000;
            endcase
        end
    end

    assign switching = (st_q == RPSS_SOFT) || (st_q == RPSS_RUN);
    assign ocp_lim   = (st_q == RPSS_SOFT) ? 8'(`RPSS_OCP_SS_LIMIT) : 8'(`RPSS_OCP_LIMIT);
    assign zcs_ev    = zcs && (blank_q == 4'h0) && (hi_q || lo_q);
    assign ocp_ev    = ocp && (hi_q || lo_q);
    assign cyc_end   = lo_prev_q && !req_lo; // one-cycle pulse when the low-side request drops

    // gate pulses, blanking and cycle bookkeeping
    always_comb begin
        hi_d = 1'b0;
        lo_d = 1'b0;
        if (switching) begin
            hi_d = req_hi && (hi_q ? !(zcs_ev || ocp) : !hi_prev_q);
            lo_d = req_lo && !hi_d && (lo_q ? !(zcs_ev || ocp) : !lo_prev_q);
        end
        hi_prev_d = req_hi && (hi_q || hi_prev_q);
        lo_prev_d = req_lo && (lo_q || lo_prev_q);
        if ((hi_d && !hi_q) || (lo_d && !lo_q)) blank_d = 4'(BLANK_CYC);
        else if (blank_q != 4'h0) blank_d = blank_q - 4'h1;
        else blank_d = blank_q;
        cyc_ocp_d  = cyc_end ? 1'b0 : (cyc_ocp_q || ocp_ev);
        zcs_seen_d = cyc_end ? 1'b0 : (zcs_seen_q || zcs_ev);
    end

    // main sequence and fault timers
    always_comb begin
        st_d    = st_q;
        cause_d = cause_q;
        idle_d  = idle_q;
        zcs_t_d = zcs_t_q;
        olp_t_d = olp_t_q;
        ss_t_d  = ss_t_q;
        ramp_d  = ramp_q;
        ocp_n_d = ocp_n_q;
        prog_d  = 1'b0;
        chg_d   = chg_q;
        unique case (st_q)
            RPSS_OFF: begin
                chg_d = hv_en && !a_self;
                if (a_uvr) st_d = a_self ? RPSS_PROGRAM : (hv_en ? RPSS_CHARGE : RPSS_PROGRAM);
            end
            RPSS_CHARGE: begin
                chg_d = 1'b1;
                if (a_uvr) st_d = RPSS_PROGRAM;
            end
            RPSS_PROGRAM: begin
                if (hv_en && !a_rech) chg_d = 1'b1;
                if (i_done && (a_self || !hv_en)) begin
                    prog_d = 1'b1;
                    chg_d  = 1'b0;
                    ramp_d = 8'h00;
                    ss_t_d = 32'h0;
                    st_d   = RPSS_SOFT;
                end
            end
            RPSS_SOFT, RPSS_RUN: begin
                if (!a_rech && hv_en) chg_d = 1'b1;
                else if (a_self) chg_d = 1'b0;
                if (ss_t_q >= SS_STEP_CYC - 1) begin
                    ss_t_d = 32'h0;
                    if (ramp_q != 8'hFF) ramp_d = ramp_q + 8'h01;
                end else ss_t_d = ss_t_q + 32'h1;
                if (zcs_ev && ramp_q != 8'h00) ramp_d = ramp_q - 8'h01;
                if (st_q == RPSS_SOFT && ramp_q > SS_MIN && demand_q[7:0] <= ramp_q) st_d = RPSS_RUN;
                zcs_t_d = zcs_seen_q || zcs_ev ? zcs_t_q + 32'h1 : (cyc_end ? 32'h0 : zcs_t_q);
                olp_t_d = olp ? olp_t_q + 32'h1 : 32'h0;
                if (cyc_end) ocp_n_d = cyc_ocp_q ? ocp_n_q + 8'h01 : 8'h00;
                if (zcs_t_q >= ZCS_FAULT_CYC) begin st_d = RPSS_FAULT; cause_d = RPSS_F_ZCS; end
                if (ocp_n_q >= ocp_lim) begin st_d = RPSS_FAULT; cause_d = RPSS_F_OCP; end
                if (olp_t_q >= OLP_CYC) begin st_d = RPSS_FAULT; cause_d = RPSS_F_OLP; end
                if (st_q == RPSS_RUN && !a_stop) begin st_d = RPSS_FAULT; cause_d = RPSS_F_UV; end
                if (st_d == RPSS_FAULT) begin
                    idle_d  = 32'h0;
                    zcs_t_d = 32'h0;
                    olp_t_d = 32'h0;
                    ocp_n_d = 8'h00;
                    chg_d   = 1'b0;
                end
            end
            RPSS_FAULT: begin
                chg_d = 1'b0;
                if (idle_q < FAULT_IDLE_CYC) idle_d = idle_q + 32'h1;
                else if (retry_en && !ovp) st_d = RPSS_OFF;
            end
            default: st_d = RPSS_OFF;
        endcase
        if (ovp && st_q != RPSS_FAULT) begin
            st_d    = RPSS_FAULT;
            cause_d = RPSS_F_OVP;
            idle_d  = 32'h0;
        end
        if (!hv_en && !a_uvf && st_q != RPSS_FAULT) st_d = RPSS_OFF;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= `RPSS_CTRL_RESET;
            demand_q <= 32'h0;
            wr_pend_q <= 1'b0;
            wr_addr_q <= 12'h0;
            rdata_q <= 32'h0;
            st_q <= RPSS_OFF;
            cause_q <= RPSS_F_NONE;
            idle_q <= 32'h0;
            zcs_t_q <= 32'h0;
            olp_t_q <= 32'h0;
            ss_t_q <= 32'h0;
            ramp_q <= 8'h00;
            ocp_n_q <= 8'h00;
            blank_q <= 4'h0;
            hi_q <= 1'b0;
            lo_q <= 1'b0;
            hi_prev_q <= 1'b0;
            lo_prev_q <= 1'b0;
            cyc_ocp_q <= 1'b0;
            zcs_seen_q <= 1'b0;
            prog_q <= 1'b0;
            chg_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            demand_q <= demand_d;
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            rdata_q <= rdata_d;
            st_q <= st_d;
            cause_q <= cause_d;
            idle_q <= idle_d;
            zcs_t_q <= zcs_t_d;
            olp_t_q <= olp_t_d;
            ss_t_q <= ss_t_d;
            ramp_q <= ramp_d;
            ocp_n_q <= ocp_n_d;
            blank_q <= blank_d;
            hi_q <= hi_d;
            lo_q <= lo_d;
            hi_prev_q <= hi_prev_d;
            lo_prev_q <= lo_prev_d;
            cyc_ocp_q <= cyc_ocp_d;
            zcs_seen_q <= zcs_seen_d;
            prog_q <= prog_d;
            chg_q <= chg_d;
        end
    end

    // outputs to drivers and supply logic
    assign high_side_gate  = hi_q;
    assign low_side_gate   = lo_q;
    assign charge_low_en   = chg_q && !a_short;
    assign charge_high_en  = chg_q && a_short;
    assign rail_5v_en      = (st_q != RPSS_OFF && st_q != RPSS_CHARGE) || a_uvr;
    assign program_sample  = prog_q;
    assign timing_pin_high = hv_en && (st_q == RPSS_CHARGE || st_q == RPSS_PROGRAM
                             || (st_q == RPSS_FAULT && a_uvf));
    assign power_limit     = olp && switching;
    assign soft_start_ramp = ramp_q;
    assign turnoff_level   = (st_q == RPSS_SOFT && ramp_q < demand_q[7:0]) ? ramp_q : demand_q[7:0];

    property p_gate_excl;
        @(posedge hclk) disable iff (!hresetn) !(hi_q && lo_q);
    endproperty
    a_gate_excl: assert property (p_gate_excl) else $error("both gates high");

    property p_fault_block;
        @(posedge hclk) disable iff (!hresetn) st_q == RPSS_FAULT |-> ##1 (!hi_q && !lo_q);
    endproperty
    a_fault_block: assert property (p_fault_block) else $error("gate in fault");

    property p_ocp_cut;
        @(posedge hclk) disable iff (!hresetn) (hi_q && ocp) |=> !hi_q;
    endproperty
    a_ocp_cut: assert property (p_ocp_cut) else $error("ocp did not end pulse");

    property p_zcs_cut;
        @(posedge hclk) disable iff (!hresetn) (lo_q && zcs && blank_q == 4'h0) |=> !lo_q;
    endproperty
    a_zcs_cut: assert property (p_zcs_cut) else $error("zcs did not end pulse");

    property p_blank;
        @(posedge hclk) disable iff (!hresetn) (hi_q && !$past(hi_q)) |-> blank_q != 4'h0;
    endproperty
    a_blank: assert property (p_blank) else $error("no blanking at gate rise");

    property p_ovp;
        @(posedge hclk) disable iff (!hresetn) (ovp && st_q != RPSS_FAULT) |=> st_q == RPSS_FAULT;
    endproperty
    a_ovp: assert property (p_ovp) else $error("ovp missed");

    property p_ocp_count;
        @(posedge hclk) disable iff (!hresetn) (st_q == RPSS_RUN && ocp_n_q >= 8'd7) |=> st_q == RPSS_FAULT;
    endproperty
    a_ocp_count: assert property (p_ocp_count) else $error("ocp count fault missed");

    property p_charge_mux;
        @(posedge hclk) disable iff (!hresetn) !(charge_low_en && charge_high_en);
    endproperty
    a_charge_mux: assert property (p_charge_mux) else $error("both charge currents");

    property p_pick_lower;
        @(posedge hclk) disable iff (!hresetn) st_q == RPSS_SOFT |-> turnoff_level <= demand_q[7:0];
    endproperty
    a_pick_lower: assert property (p_pick_lower) else $error("turn-off level not lower");
endmodule
`default_nettype wire

/* File: dv/rpss_partner.sv */
// analog threshold and current-sense comparator model on the far side
`timescale 1ns/1ps
`default_nettype none
module rpss_partner #(
    parameter logic [7:0] TH_SHORT = 8'h10,
    parameter logic [7:0] TH_STOP  = 8'h20,
    parameter logic [7:0] TH_UVF   = 8'h30,
    parameter logic [7:0] TH_RECH  = 8'h40,
    parameter logic [7:0] TH_UVR   = 8'h50,
    parameter logic [7:0] TH_SELF  = 8'h60,
    parameter logic [7:0] TH_OV    = 8'hE0
) (
    input  wire logic [7:0] bias_lvl,
    input  wire logic       ocp_on,
    input  wire logic       high_side_gate,
    input  wire logic       low_side_gate,
    output logic            ocp_cmp,
    output logic            bias_ov,
    output logic            bias_above_short,
    output logic            bias_above_uvlo_r,
    output logic            bias_above_uvlo_f,
    output logic            bias_above_self,
    output logic            bias_above_recharge,
    output logic            bias_above_stop
);
    // current sense only trips while a switch conducts
    assign ocp_cmp = ocp_on & (high_side_gate | low_side_gate);
    // bias level against each supply threshold
    assign bias_ov             = bias_lvl > TH_OV;
    assign bias_above_short    = bias_lvl > TH_SHORT;
    assign bias_above_uvlo_r   = bias_lvl > TH_UVR;
    assign bias_above_uvlo_f   = bias_lvl > TH_UVF;
    assign bias_above_self     = bias_lvl > TH_SELF;
    assign bias_above_recharge = bias_lvl > TH_RECH;
    assign bias_above_stop     = bias_lvl > TH_STOP;
endmodule
`default_nettype wire

/* File: dv/rpss_seq_tb.sv */
// self-checking bench of the protection and startup sequencer
`timescale 1ns/1ps
`default_nettype none
`include "rpss_regs.svh"
module rpss_seq_tb
    import rpss_pkg::*;
;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, gate_req_hi, gate_req_lo, zcs_cmp, olp_cmp;
    logic        init_done, ocp_on, ocp_cmp, bias_ov, bias_above_short, bias_above_uvlo_r, bias_above_uvlo_f;
    logic        bias_above_self, bias_above_recharge, bias_above_stop, high_side_gate, low_side_gate;
    logic        charge_low_en, charge_high_en, rail_5v_en, program_sample, timing_pin_high, power_limit;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata;
    logic [7:0]  bias_lvl, soft_start_ramp, turnoff_level;
    int          error_cnt, checks;

    rpss_seq #(.FAULT_IDLE_CYC(100), .SS_STEP_CYC(1), .ZCS_FAULT_CYC(20), .OLP_CYC(20)) dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hrdata, .hreadyout, .hresp(), .gate_req_hi, .gate_req_lo, .zcs_cmp, .ocp_cmp, .olp_cmp,
        .bias_ov, .bias_above_short, .bias_above_uvlo_r, .bias_above_uvlo_f, .bias_above_self,
        .bias_above_recharge, .bias_above_stop, .init_done, .high_side_gate, .low_side_gate,
        .charge_low_en, .charge_high_en, .rail_5v_en, .program_sample, .timing_pin_high,
        .power_limit, .soft_start_ramp, .turnoff_level);

    rpss_partner far (
        .bias_lvl, .ocp_on, .high_side_gate, .low_side_gate, .ocp_cmp, .bias_ov, .bias_above_short,
        .bias_above_uvlo_r, .bias_above_uvlo_f, .bias_above_self, .bias_above_recharge, .bias_above_stop);

    // clock generation
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    task automatic print_verdict();
        if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one single-word bus transfer, address phase then data phase
    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= 3'b010;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask

    // poll the state field until it matches or the poll budget runs out
    task automatic wait_st(input rpss_state_t s, input int lim);
        logic [31:0] r;
        for (int i = 0; i < lim; i++) begin
            ahb(1'b0, `RPSS_STATUS_ADDR, 32'h0, r);
            if (r[2:0] === s) break;
        end
        chk({29'h0, r[2:0]}, {29'h0, s});
    endtask

    task automatic cause(input rpss_fault_t f);
        logic [31:0] r;
        ahb(1'b0, `RPSS_STATUS_ADDR, 32'h0, r);
        chk({29'h0, r[18:16]}, {29'h0, f});
    endtask

    // one switching cycle, gate levels judged late in each pulse
    task automatic gcyc(input logic e);
        gate_req_hi <= 1'b1;
        repeat (12) @(posedge hclk);
        chk({31'h0, high_side_gate}, {31'h0, e});
        gate_req_hi <= 1'b0;
        repeat (4) @(posedge hclk);
        gate_req_lo <= 1'b1;
        repeat (12) @(posedge hclk);
        chk({31'h0, low_side_gate}, {31'h0, e});
        gate_req_lo <= 1'b0;
        repeat (4) @(posedge hclk);
    endtask

    task automatic do_reset();
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
    endtask

    task automatic settle(input logic [7:0] b);
        bias_lvl <= b;
        repeat (6) @(posedge hclk);
    endtask

    task automatic t_regs();
        rd_chk(`RPSS_CTRL_ADDR, `RPSS_CTRL_RESET);
        wr(12'h010, 32'hFFFF_FFFF);
        rd_chk(12'h010, 32'h0);
        wr(`RPSS_DEMAND_ADDR, 32'h20);
        rd_chk(`RPSS_DEMAND_ADDR, 32'h20);
    endtask

    task automatic t_start();
        settle(8'h08);
        chk({charge_low_en, charge_high_en}, 32'h2);
        settle(8'h18);
        chk({charge_low_en, charge_high_en}, 32'h1);
        settle(8'h58);
        chk({rail_5v_en, timing_pin_high}, 32'h3);
        settle(8'h68);
        init_done <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            @(posedge hclk);
            if (program_sample === 1'b1) break;
        end
        chk({31'h0, program_sample}, 32'h1);
        settle(8'h68);
        chk({charge_low_en, charge_high_en, timing_pin_high}, 32'h0);
        repeat (20) begin
            @(posedge hclk);
            chk(turnoff_level, (soft_start_ramp < 8'h20) ? soft_start_ramp : 8'h20);
        end
        wait_st(RPSS_RUN, 100);
        chk({31'h0, soft_start_ramp >= 8'h40}, 32'h1);
        settle(8'h48);
        chk({31'h0, charge_high_en}, 32'h0);
        settle(8'h38);
        chk({31'h0, charge_high_en}, 32'h1);
        settle(8'h68);
    endtask

    task automatic t_ocp();
        ocp_on <= 1'b1;
        repeat (6) gcyc(1'b0);
        wait_st(RPSS_RUN, 1);
        gcyc(1'b0);
        wait_st(RPSS_FAULT, 10);
        cause(RPSS_F_OCP);
        ocp_on <= 1'b0;
        gcyc(1'b0);
    endtask

    task automatic t_retry();
        wr(`RPSS_CTRL_ADDR, 32'h3);
        repeat (6) @(posedge hclk);
        chk({charge_low_en, charge_high_en, rail_5v_en}, 32'h1);
        wait_st(RPSS_RUN, 200);
        bias_lvl <= 8'hF0;
        wait_st(RPSS_FAULT, 10);
        cause(RPSS_F_OVP);
        chk({high_side_gate, low_side_gate, timing_pin_high}, 32'h1);
        settle(8'h68);
        repeat (54) @(posedge hclk);
        wait_st(RPSS_FAULT, 1);
        wait_st(RPSS_RUN, 200);
    endtask

    task automatic t_zcs();
        zcs_cmp <= 1'b1;
        gcyc(1'b0);
        wait_st(RPSS_FAULT, 10);
        cause(RPSS_F_ZCS);
        zcs_cmp <= 1'b0;
        wait_st(RPSS_RUN, 200);
    endtask

    task automatic overload_time_limit();
        olp_cmp <= 1'b1;
        repeat (5) @(posedge hclk);
        chk({31'h0, power_limit}, 32'h1);
        wait_st(RPSS_FAULT, 20);
        cause(RPSS_F_OLP);
        olp_cmp <= 1'b0;
        wait_st(RPSS_RUN, 200);
        bias_lvl <= 8'h18;
        wait_st(RPSS_FAULT, 10);
        cause(RPSS_F_UV);
    endtask

    // watchdog against a hung handshake or state wait
    initial begin
        repeat (30000) @(posedge hclk);
        error_cnt++;
        print_verdict();
    end

    // main sequence
    initial begin
        {hresetn, hsel, hwrite, gate_req_hi, gate_req_lo, zcs_cmp, olp_cmp, init_done, ocp_on} = 9'h0;
        {haddr, htrans, hsize, hwdata} = 49'h0;
        bias_lvl = 8'h08;
        error_cnt = 0;
        checks = 0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_start();
        t_ocp();
        do_reset();
        t_retry();
        t_zcs();
        overload_time_limit();
        print_verdict();
    end
endmodule
`default_nettype wire

/* File: pkg/rpss_pkg.sv */
// types of the protection and startup sequencer
package rpss_pkg;
    typedef enum logic [2:0] {
        RPSS_OFF     = 3'b000,
        RPSS_CHARGE  = 3'b001,
        RPSS_PROGRAM = 3'b011,
        RPSS_SOFT    = 3'b010,
        RPSS_RUN     = 3'b110,
        RPSS_FAULT   = 3'b111
    } rpss_state_t;
    typedef enum logic [2:0] {
        RPSS_F_NONE = 3'h0,
        RPSS_F_ZCS  = 3'h1,
        RPSS_F_OCP  = 3'h2,
        RPSS_F_OLP  = 3'h3,
        RPSS_F_OVP  = 3'h4,
        RPSS_F_UV   = 3'h5
    } rpss_fault_t;
endpackage

/* File: pkg/rpss_regs.svh */
// register offsets, fields, reset values and timing counts of the protection sequencer
`ifndef RPSS_REGS_SVH
`define RPSS_REGS_SVH
`define RPSS_CTRL_ADDR      12'h000
`define RPSS_STATUS_ADDR    12'h004
`define RPSS_DEMAND_ADDR    12'h008
`define RPSS_CMPVAL_ADDR    12'h00C
`define RPSS_CTRL_RESET     32'h0000_0001
`define RPSS_CTRL_HV_BIT    0
`define RPSS_CTRL_RETRY_BIT 1
`define RPSS_FAULT_IDLE_MS  1000
`define RPSS_SS_TIME_MS     25
`define RPSS_CLK_HZ         25000000
`define RPSS_OCP_LIMIT      7
`define RPSS_OCP_SS_LIMIT   50
`define RPSS_BLANK_NS       200
`endif
